// file: rtl/vtpg_defines.svh
`ifndef VTPG_DEFINES_SVH
`define VTPG_DEFINES_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define VTPG_ADDR_SEL_CTRL  8'h64
`define VTPG_ADDR_CONFIG    8'h65
`define VTPG_ADDR_IND_PTR   8'h66
`define VTPG_ADDR_IND_VAL   8'h67
`define VTPG_RST_SEL_CTRL   8'h10
`define VTPG_RST_CONFIG     8'h00
`define VTPG_RST_IND        8'h00
// Field positions
`define VTPG_SEL_HI         7
`define VTPG_SEL_LO         4
`define VTPG_EN_BIT         0
`define VTPG_B18_BIT        4
`define VTPG_EXTCLK_BIT     3
`define VTPG_TSEL_BIT       2
`define VTPG_INV_BIT        1
`define VTPG_SCROLL_BIT     0
// ----------------------------------------
// Indirect register indices
// ----------------------------------------
`define VTPG_IND_TOT_H_LO   8'h00
`define VTPG_IND_TOT_H_HI   8'h01
`define VTPG_IND_TOT_V_LO   8'h02
`define VTPG_IND_TOT_V_HI   8'h03
`define VTPG_IND_ACT_H_LO   8'h04
`define VTPG_IND_ACT_H_HI   8'h05
`define VTPG_IND_ACT_V_LO   8'h06
`define VTPG_IND_ACT_V_HI   8'h07
`define VTPG_IND_HS_W       8'h08
`define VTPG_IND_VS_W       8'h09
`define VTPG_IND_HBP        8'h0a
`define VTPG_IND_VBP        8'h0b
`define VTPG_IND_SYNC_CFG   8'h0c
`define VTPG_IND_DWELL      8'h0d
`define VTPG_IND_RED        8'h0e
`define VTPG_IND_GREEN      8'h0f
`define VTPG_IND_BLUE       8'h10
`define VTPG_IND_PEN_LO     8'h11
`define VTPG_IND_PEN_HI     8'h12
// ----------------------------------------
// Pattern codes and levels
// ----------------------------------------
`define VTPG_PAT_WHITE      4'h1
`define VTPG_PAT_BLACK      4'h2
`define VTPG_PAT_RED        4'h3
`define VTPG_PAT_GREEN      4'h4
`define VTPG_PAT_BLUE       4'h5
`define VTPG_PAT_HFIRST     4'h6
`define VTPG_PAT_HLAST      4'h8
`define VTPG_PAT_VFIRST     4'h9
`define VTPG_PAT_VLAST      4'hd
`define VTPG_PAT_CUSTOM     4'he
`define VTPG_PAT_LAST       4'he
`define VTPG_LEVELS_24      12'h100
`define VTPG_LEVELS_18      12'h040
`define VTPG_MASK_18        24'hfcfcfc
`endif

// file: rtl/vtpg_pkg.sv
`default_nettype none
package vtpg_pkg;
  // One pixel with its timing strobes
  typedef struct packed {
    logic        de;
    logic        hs;
    logic        vs;
    logic [23:0] rgb;
  } vtpg_video_t;
  // Serial control bus access, one cycle per request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vtpg_reg_req_t;
endpackage
`default_nettype wire

// file: rtl/vtpg_top.sv
`include "vtpg_defines.svh"
`default_nettype none
// Behaviour
// RULE_01: Select field bits 7:4 of control register chooses the fixed pattern.
// RULE_02: Scaled ramps spread evenly over the active width or height.
// RULE_03: Auto-scroll ignores the fixed select field.
// RULE_04: Codes 1-5 give white, black, red, green, blue; inverted gives complements.
// RULE_05: Codes 6-8 horizontal ramps, 9-13 vertical ramps, inversion complements them.
// RULE_06: Code 14 outputs custom red, green, blue levels, or their inversion.
// RULE_07: Software never programs select codes 0 or 15.
// RULE_08: Control bit 0 switches the generator on or off.
// RULE_09: 18-bit mode uses 64 levels on six MSBs; else 256 levels.
// RULE_10: Internal timing clocks from pixel clock if external bit set, else divider.
// RULE_11: Clock source bit has no effect under external timing.
// RULE_12: Timing select set makes the generator produce programmed timing.
// RULE_13: Timing select clear follows external clock, enable and syncs.
// RULE_14: Invert bit outputs bitwise complement of the pattern.
// RULE_15: Auto-scroll moves to next enabled pattern after the dwell frame count.
// RULE_16: Software writes the indirect pointer before each indirect data access.
// RULE_17: Indirect data writes store to, and reads return, the addressed register.
// RULE_18: While enabled, generated pixels replace the parallel video input.
module vtpg_top
  import vtpg_pkg::*;
#(
  parameter int IND_DEPTH = 32,  // Indirect registers implemented
  parameter int CLK_DIV   = 4    // Internal divided pixel clock ratio
) (
  input  wire logic          i_clock,
  input  wire logic          i_nrst,
  input  wire vtpg_reg_req_t i_reg,
  output logic [7:0]         o_reg_rdata,
  input  wire logic          i_pclk_pin,
  input  wire vtpg_video_t   i_video,
  output vtpg_video_t        o_video
);
  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [7:0] sel_ctrl_r, config_r, ind_ptr_r;
  logic [7:0] ind_mem [IND_DEPTH];
  logic       gen_en, b18, extclk, tsel, inv, scroll;
  logic [3:0] fixed_sel;
  assign fixed_sel = sel_ctrl_r[`VTPG_SEL_HI:`VTPG_SEL_LO];          // [RULE_01]
  assign gen_en    = sel_ctrl_r[`VTPG_EN_BIT];                         // [RULE_08]
  assign b18       = config_r[`VTPG_B18_BIT];
  assign extclk    = config_r[`VTPG_EXTCLK_BIT];
  assign tsel      = config_r[`VTPG_TSEL_BIT];
  assign inv       = config_r[`VTPG_INV_BIT];
  assign scroll    = config_r[`VTPG_SCROLL_BIT];
  // Indirect reads beyond the implemented depth return zero
  function automatic logic [7:0] ind_rd(input logic [7:0] a);
    ind_rd = (32'(a) < IND_DEPTH) ? ind_mem[a[$clog2(IND_DEPTH)-1:0]] : 8'h00;
  endfunction
  // Register writes; reserved bits are held at zero
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      sel_ctrl_r <= `VTPG_RST_SEL_CTRL;
      config_r   <= `VTPG_RST_CONFIG;
      ind_ptr_r  <= `VTPG_RST_IND;
    end else if (i_reg.wr) begin
      case (i_reg.addr)
        `VTPG_ADDR_SEL_CTRL: sel_ctrl_r <= i_reg.wdata & 8'hf1;
        `VTPG_ADDR_CONFIG:   config_r   <= i_reg.wdata & 8'h1f;
        `VTPG_ADDR_IND_PTR:  ind_ptr_r  <= i_reg.wdata;             // [RULE_16]
        default: ;
      endcase
    end
  end
  // Indirect store through the pointer
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      for (int k = 0; k < IND_DEPTH; k++) begin
        ind_mem[k] <= `VTPG_RST_IND;
      end
    end else if (i_reg.wr && i_reg.addr == `VTPG_ADDR_IND_VAL && 32'(ind_ptr_r) < IND_DEPTH) begin
      ind_mem[ind_ptr_r[$clog2(IND_DEPTH)-1:0]] <= i_reg.wdata;       // [RULE_17]
    end
  end
  // Read data is registered, valid the cycle after the read strobe
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg.rd) begin
      case (i_reg.addr)
        `VTPG_ADDR_SEL_CTRL: o_reg_rdata <= sel_ctrl_r;
        `VTPG_ADDR_CONFIG:   o_reg_rdata <= config_r;
        `VTPG_ADDR_IND_PTR:  o_reg_rdata <= ind_ptr_r;
        `VTPG_ADDR_IND_VAL:  o_reg_rdata <= ind_rd(ind_ptr_r);     // [RULE_17]
        default:             o_reg_rdata <= 8'h00;
      endcase
    end
  end
  // Indirect fields; a combinational process so later table writes are seen
  logic [11:0] tot_h, tot_v, act_h, act_v;
  logic [7:0]  hs_w, vs_w, hbp, vbp, dwell, sync_cfg;
  logic [13:0] pat_en;
  always_comb begin
    tot_h    = 12'({ind_rd(`VTPG_IND_TOT_H_HI), ind_rd(`VTPG_IND_TOT_H_LO)});  // Upper nibble unused
    tot_v    = 12'({ind_rd(`VTPG_IND_TOT_V_HI), ind_rd(`VTPG_IND_TOT_V_LO)});
    act_h    = 12'({ind_rd(`VTPG_IND_ACT_H_HI), ind_rd(`VTPG_IND_ACT_H_LO)});
    act_v    = 12'({ind_rd(`VTPG_IND_ACT_V_HI), ind_rd(`VTPG_IND_ACT_V_LO)});
    hs_w     = ind_rd(`VTPG_IND_HS_W);
    vs_w     = ind_rd(`VTPG_IND_VS_W);
    hbp      = ind_rd(`VTPG_IND_HBP);
    vbp      = ind_rd(`VTPG_IND_VBP);
    dwell    = ind_rd(`VTPG_IND_DWELL);
    pat_en   = 14'({ind_rd(`VTPG_IND_PEN_HI), ind_rd(`VTPG_IND_PEN_LO)} >> 1);  // Code 1 sits in bit 1
    sync_cfg = ind_rd(`VTPG_IND_SYNC_CFG);
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // All pins share a three-stage chain so data stays aligned with its strobes
  logic [27:0] sy1_r, sy2_r, sy3_r, in_lvl_r;
  vtpg_video_t in_v;
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      sy1_r    <= 28'h0;
      sy2_r    <= 28'h0;
      sy3_r    <= 28'h0;
      in_lvl_r <= 28'h0;
    end else begin
      sy1_r <= {i_pclk_pin, i_video};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      for (int k = 0; k < 28; k++) begin
        if (sy2_r[k] == sy3_r[k]) begin
          in_lvl_r[k] <= sy3_r[k];
        end
      end
    end
  end
  logic ext_edge;
  assign ext_edge = sy2_r[27] && sy3_r[27] && !in_lvl_r[27];
  assign in_v     = in_lvl_r[26:0];
  // Divider for the internal pixel clock
  logic [7:0] div_cnt_r;
  logic       div_tick;
  assign div_tick = (32'(div_cnt_r) == CLK_DIV - 1);
  always_ff @(posedge i_clock) begin
    if (!i_nrst || div_tick) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end
  // Clock source only matters under internal timing
  logic tick;
  assign tick = (tsel && !extclk) ? div_tick : ext_edge;                // [RULE_10] [RULE_11]

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  logic [11:0] h_cnt_r, v_cnt_r, h_st, v_st;
  logic        h_wrap, v_wrap, int_de, int_hs, int_vs, cur_de, de_prev_r, vs_prev_r;
  assign h_wrap = (h_cnt_r >= tot_h - 12'h001);
  assign v_wrap = (v_cnt_r >= tot_v - 12'h001);
  assign h_st   = 12'(hs_w) + 12'(hbp);
  assign v_st   = 12'(vs_w) + 12'(vbp);
  assign int_de = h_cnt_r >= h_st && h_cnt_r < h_st + act_h && v_cnt_r >= v_st && v_cnt_r < v_st + act_v;
  // Sync config bit 0/1 flips the polarity of horizontal/vertical sync
  assign int_hs = (h_cnt_r < 12'(hs_w)) ^ sync_cfg[0];
  assign int_vs = (v_cnt_r < 12'(vs_w)) ^ sync_cfg[1];
  assign cur_de = tsel ? int_de : in_v.de;                              // [RULE_12] [RULE_13]
  // Raster counters advance once per pixel tick
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      h_cnt_r <= 12'h000;
      v_cnt_r <= 12'h000;
    end else if (tick) begin
      h_cnt_r <= h_wrap ? 12'h000 : h_cnt_r + 12'h001;                // [RULE_12]
      if (h_wrap) begin
        v_cnt_r <= v_wrap ? 12'h000 : v_cnt_r + 12'h001;
      end
    end
  end
  // Falling edge of enable marks line end; vertical sync rising edge, or counter wrap under internal timing, marks frame start
  logic line_end, frame_start;
  assign line_end    = tick && de_prev_r && !cur_de;
  assign frame_start = tsel ? (tick && h_wrap && v_wrap) : (in_v.vs && !vs_prev_r);
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      de_prev_r <= 1'b0;
      vs_prev_r <= 1'b0;
    end else begin
      vs_prev_r <= in_v.vs;
      if (tick) begin
        de_prev_r <= cur_de;
      end
    end
  end

  // ----------------------------------------
  // Ramp levels
  // ----------------------------------------
  // Level = position * level count / active size: even for any size, paid for with a divider
  logic [11:0] levels, hpos_r, vpos_r;
  logic [7:0]  hlvl, vlvl, lvl_max;
  logic [19:0] hq, vq;
  assign levels  = b18 ? `VTPG_LEVELS_18 : `VTPG_LEVELS_24;            // [RULE_09]
  assign lvl_max = 8'(levels - 12'h001);
  always_comb begin
    hq   = (act_h == 12'h000) ? 20'h00000 : (20'(hpos_r) * 20'(levels)) / 20'(act_h);  // [RULE_02]
    vq   = (act_v == 12'h000) ? 20'h00000 : (20'(vpos_r) * 20'(levels)) / 20'(act_v);  // [RULE_02]
    hlvl = (hq > 20'(lvl_max)) ? lvl_max : 8'(hq);
    vlvl = (vq > 20'(lvl_max)) ? lvl_max : 8'(vq);
  end
  // Pixel position within the active line, and active line within the frame
  always_ff @(posedge i_clock) begin
    if (!i_nrst || (tick && !cur_de)) begin
      hpos_r <= 12'h000;
    end else if (tick) begin
      hpos_r <= hpos_r + 12'h001;
    end
  end
  always_ff @(posedge i_clock) begin
    if (!i_nrst || frame_start) begin
      vpos_r <= 12'h000;
    end else if (line_end) begin
      vpos_r <= vpos_r + 12'h001;
    end
  end

  // ----------------------------------------
  // Auto-scroll
  // ----------------------------------------
  logic [3:0] scroll_pat_r, cur_pat;
  logic [7:0] frm_cnt_r;
  function automatic logic [3:0] next_pat(input logic [3:0] p, input logic [13:0] en);
    logic [3:0] c;
    c = p;
    next_pat = p;
    for (int k = 0; k < 14; k++) begin
      c = (c >= `VTPG_PAT_LAST) ? `VTPG_PAT_WHITE : c + 4'h1;
      if (en[c - 4'h1] && next_pat == p) begin
        next_pat = c;
      end
    end
  endfunction
  always_ff @(posedge i_clock) begin
    if (!i_nrst || !scroll) begin
      frm_cnt_r    <= 8'h00;
      scroll_pat_r <= `VTPG_PAT_WHITE;
    end else if (frame_start) begin
      if (frm_cnt_r + 8'h01 >= dwell) begin
        frm_cnt_r    <= 8'h00;
        scroll_pat_r <= next_pat(scroll_pat_r, pat_en);                 // [RULE_15]
      end else begin
        frm_cnt_r <= frm_cnt_r + 8'h01;
      end
    end
  end
  assign cur_pat = scroll ? scroll_pat_r : fixed_sel;                   // [RULE_03] [RULE_01]

  // ----------------------------------------
  // Pattern colour and output
  // ----------------------------------------
  logic [23:0] pat_rgb, gen_rgb;
  logic [7:0]  hl, vl;
  assign hl = b18 ? {hlvl[5:0], 2'b00} : hlvl;                          // [RULE_09]
  assign vl = b18 ? {vlvl[5:0], 2'b00} : vlvl;
  always_comb begin
    case (cur_pat)
      `VTPG_PAT_WHITE:  pat_rgb = 24'hffffff;                           // [RULE_04]
      `VTPG_PAT_BLACK:  pat_rgb = 24'h000000;
      `VTPG_PAT_RED:    pat_rgb = 24'hff0000;
      `VTPG_PAT_GREEN:  pat_rgb = 24'h00ff00;
      `VTPG_PAT_BLUE:   pat_rgb = 24'h0000ff;
      4'h6:             pat_rgb = {hl, hl, hl};                         // [RULE_05]
      4'h7:             pat_rgb = {hl, 8'h00, 8'h00};
      `VTPG_PAT_HLAST:  pat_rgb = {8'h00, hl, 8'h00};
      `VTPG_PAT_VFIRST: pat_rgb = {vl, vl, vl};
      4'ha:             pat_rgb = {vl, 8'h00, 8'h00};
      4'hb:             pat_rgb = {8'h00, vl, 8'h00};
      4'hc:             pat_rgb = {8'h00, vl, 8'h00};
      `VTPG_PAT_VLAST:  pat_rgb = {8'h00, 8'h00, vl};
      `VTPG_PAT_CUSTOM: pat_rgb = {ind_rd(`VTPG_IND_RED), ind_rd(`VTPG_IND_GREEN),
                                   ind_rd(`VTPG_IND_BLUE)};             // [RULE_06]
      default:          pat_rgb = 24'h000000;                           // Reserved codes
    endcase
  end
  assign gen_rgb = (inv ? ~pat_rgb : pat_rgb) & (b18 ? `VTPG_MASK_18 : 24'hffffff); // [RULE_14] [RULE_09]
  // Generated pixels replace the input stream while the generator runs
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_video <= '0;
    end else if (!gen_en) begin
      o_video <= in_v;                                                  // [RULE_08]
    end else if (tsel) begin
      o_video <= '{de: int_de, hs: int_hs, vs: int_vs, rgb: gen_rgb};   // [RULE_18] [RULE_12]
    end else begin
      o_video <= '{de: in_v.de, hs: in_v.hs, vs: in_v.vs, rgb: gen_rgb}; // [RULE_18] [RULE_13]
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_off_pass;
    @(posedge i_clock) disable iff (!i_nrst) !gen_en |=> o_video == $past(in_v);
  endproperty
  a_off_pass: assert property (p_off_pass) else $error("disabled output not passthrough"); // [RULE_08]
  property p_on_replace;
    @(posedge i_clock) disable iff (!i_nrst) gen_en && !tsel |=> o_video.rgb == $past(gen_rgb);
  endproperty
  a_on_replace: assert property (p_on_replace) else $error("generated pixel not output"); // [RULE_18]
  property p_ext_timing;
    @(posedge i_clock) disable iff (!i_nrst) gen_en && !tsel |=> o_video.de == $past(in_v.de);
  endproperty
  a_ext_timing: assert property (p_ext_timing) else $error("external enable not followed"); // [RULE_13]
  property p_int_timing;
    @(posedge i_clock) disable iff (!i_nrst) gen_en && tsel |=> o_video.de == $past(int_de);
  endproperty
  a_int_timing: assert property (p_int_timing) else $error("internal enable not used"); // [RULE_12]
  property p_white;
    @(posedge i_clock) disable iff (!i_nrst)
      gen_en && !scroll && !b18 && fixed_sel == `VTPG_PAT_WHITE ##0 $stable(config_r)
      |=> o_video.rgb == ($past(inv) ? 24'h000000 : 24'hffffff);
  endproperty
  a_white: assert property (p_white) else $error("white pattern wrong"); // [RULE_04]
  property p_b18;
    @(posedge i_clock) disable iff (!i_nrst) gen_en && b18 |=> (o_video.rgb & 24'h030303) == 24'h0;
  endproperty
  a_b18: assert property (p_b18) else $error("18-bit low bits set"); // [RULE_09]
  property p_tick_sel;
    @(posedge i_clock) disable iff (!i_nrst) !tsel |-> tick == ext_edge;
  endproperty
  a_tick_sel: assert property (p_tick_sel) else $error("clock bit affects external timing"); // [RULE_11]
  property p_ind_rd;
    @(posedge i_clock) disable iff (!i_nrst)
      i_reg.rd && i_reg.addr == `VTPG_ADDR_IND_VAL |=> o_reg_rdata == $past(ind_rd(ind_ptr_r));
  endproperty
  a_ind_rd: assert property (p_ind_rd) else $error("indirect read wrong"); // [RULE_17]
  property p_scroll;
    @(posedge i_clock) disable iff (!i_nrst) scroll |-> cur_pat == scroll_pat_r;
  endproperty
  a_scroll: assert property (p_scroll) else $error("select used in scroll mode"); // [RULE_03]
endmodule
`default_nettype wire

// file: tb/vtpg_sink_model.sv
`default_nettype none
// ----------------------------------------
// Far-side receiver of the video stream
// ----------------------------------------
module vtpg_sink_model
  import vtpg_pkg::*;
(
  input  wire logic        i_clock,
  input  wire vtpg_video_t i_video,
  output var  int          o_de_run,
  output var  int          o_hs_run
);
  timeunit 1ns;
  timeprecision 1ps;
  int de_cnt = 0;
  int hs_cnt = 0;
  initial o_de_run = 0;
  initial o_hs_run = 0;
  // Reports only finished runs, so a run cut by a mode change shows up late
  always @(posedge i_clock) begin
    de_cnt <= i_video.de ? de_cnt + 1 : 0;
    hs_cnt <= i_video.hs ? hs_cnt + 1 : 0;
    if (!i_video.de && de_cnt != 0) o_de_run <= de_cnt;
    if (!i_video.hs && hs_cnt != 0) o_hs_run <= hs_cnt;
  end
endmodule
`default_nettype wire

// file: tb/tb_video_test_pattern_generator.sv
`include "vtpg_defines.svh"
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_video_test_pattern_generator
  import vtpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HT = 272;
  logic          clock = 1'b0;
  logic          nrst  = 1'b0;
  vtpg_reg_req_t req   = '0;
  logic [7:0]    rdata;
  logic          pclk  = 1'b0;
  vtpg_video_t   vid   = '0;
  vtpg_video_t   vout;
  int            de_run, hs_run, n_errors = 0, checked = 0, cycles = 0, ph = 0, h = 0, v = 0;
  event          pix;

  vtpg_top #(.IND_DEPTH(32), .CLK_DIV(2)) u_dut (
    .i_clock(clock), .i_nrst(nrst), .i_reg(req), .o_reg_rdata(rdata),
    .i_pclk_pin(pclk), .i_video(vid), .o_video(vout));
  vtpg_sink_model u_sink (.i_clock(clock), .i_video(vout), .o_de_run(de_run), .o_hs_run(hs_run));

  // ----------------------------------------
  // Clock, hang guard and video source
  // ----------------------------------------
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 100000) begin
      n_errors++;
      conclude();
    end
  end
  // Pixel clock of 8 system clocks: slow enough that each pixel is seen settled
  always @(posedge clock) begin
    #1;
    if (ph == 0) begin
      h = (h == HT - 1) ? 0 : h + 1;
      if (h == 0) v = (v == 3) ? 0 : v + 1;
      vid = '{de: h >= 8 && h < 264, hs: h < 4, vs: v == 0, rgb: 24'($urandom)};
      pclk = 1'b1;
      -> pix;
    end
    if (ph == 4) pclk = 1'b0;
    ph = (ph == 7) ? 0 : ph + 1;
  end

  // ----------------------------------------
  // Bus, pixel and expectation helpers
  // ----------------------------------------
  task automatic conclude();
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    #1 req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    #1 req = '0;
    @(posedge clock);
    #2 `CHK("rdata", e, rdata)
  endtask
  task automatic iw(input logic [7:0] i, input logic [7:0] d);
    wr(`VTPG_ADDR_IND_PTR, i);
    wr(`VTPG_ADDR_IND_VAL, d);
  endtask
  // Waits for the next source pixel and returns once its output has settled
  task automatic px(output vtpg_video_t s, output int hh, output int vv);
    @(pix);
    s = vid;
    hh = h;
    vv = v;
    repeat (7) @(posedge clock);
    #2;
  endtask
  task automatic seek(input int hx, input int vx);
    vtpg_video_t s;
    int          hh, vv;
    do px(s, hh, vv); while (hh != hx || vv != vx);
  endtask
  // First pixel skipped: it may have left before the new setting landed
  task automatic chk_px(input logic [23:0] e);
    vtpg_video_t s;
    int          hh, vv;
    px(s, hh, vv);
    repeat (3) begin
      px(s, hh, vv);
      `CHK("strobes", {s.de, s.hs, s.vs}, {vout.de, vout.hs, vout.vs})
      if (s.de) `CHK("rgb", e, vout.rgb)
    end
  endtask
  function automatic logic [23:0] colour(input logic [3:0] c, input logic [7:0] lvl, input logic inv, input logic b18);
    logic [23:0] m;
    case (c)
      4'h1, 4'h6, 4'h9: m = 24'hffffff;
      4'h3, 4'h7, 4'ha: m = 24'hff0000;
      4'h4, 4'h8, 4'hb, 4'hc: m = 24'h00ff00;
      4'h5, 4'hd: m = 24'h0000ff;
      default: m = 24'h000000;
    endcase
    m = m & {3{lvl}};
    if (inv) m = ~m;
    return b18 ? (m & `VTPG_MASK_18) : m;
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    vtpg_video_t s;
    int          hh, vv;
    logic [7:0]  r, g, b;
    logic        b18;
    void'($urandom(53));
    repeat (8) @(posedge clock);
    #1 nrst = 1'b1;
    // Reset values, reserved bits, unmapped place
    rd(`VTPG_ADDR_SEL_CTRL, `VTPG_RST_SEL_CTRL);
    rd(`VTPG_ADDR_CONFIG, `VTPG_RST_CONFIG);
    rd(`VTPG_ADDR_IND_PTR, `VTPG_RST_IND);
    rd(`VTPG_ADDR_IND_VAL, `VTPG_RST_IND);
    rd(8'h68, 8'h00);
    wr(`VTPG_ADDR_SEL_CTRL, 8'hee);
    rd(`VTPG_ADDR_SEL_CTRL, 8'he0);
    wr(`VTPG_ADDR_CONFIG, 8'hfe);
    rd(`VTPG_ADDR_CONFIG, 8'h1e);
    wr(`VTPG_ADDR_CONFIG, 8'h00);
    // Indirect storage, including a pointer past the implemented depth
    r = 8'($urandom);
    g = 8'($urandom);
    b = 8'($urandom);
    iw(`VTPG_IND_RED, r);
    rd(`VTPG_ADDR_IND_VAL, r);
    iw(`VTPG_IND_GREEN, g);
    rd(`VTPG_ADDR_IND_VAL, g);
    iw(`VTPG_IND_BLUE, b);
    rd(`VTPG_ADDR_IND_VAL, b);
    iw(8'h20, 8'h5a);
    rd(`VTPG_ADDR_IND_VAL, 8'h00);
    // Disabled generator passes the input through
    repeat (4) begin
      px(s, hh, vv);
      `CHK("video", s, vout)
    end
    iw(`VTPG_IND_ACT_H_LO, 8'h00);
    iw(`VTPG_IND_ACT_H_HI, 8'h01);
    iw(`VTPG_IND_ACT_V_LO, 8'h04);
    iw(`VTPG_IND_ACT_V_HI, 8'h00);
    // Solid colours, plain and inverted; only legal codes are programmed
    for (int c = 1; c < 6; c++) begin
      for (int k = 0; k < 2; k++) begin
        b18 = 1'($urandom);
        wr(`VTPG_ADDR_CONFIG, {3'b000, b18, 1'($urandom), 1'b0, k[0], 1'b0});
        wr(`VTPG_ADDR_SEL_CTRL, {c[3:0], 4'h1});
        chk_px(colour(c[3:0], 8'hff, k[0], b18));
      end
    end
    for (int k = 0; k < 4; k++) begin
      wr(`VTPG_ADDR_CONFIG, {3'b000, k[1], 2'b00, k[0], 1'b0});
      wr(`VTPG_ADDR_SEL_CTRL, 8'he1);
      chk_px(({r, g, b} ^ {24{k[0]}}) & (k[1] ? `VTPG_MASK_18 : 24'hffffff));
    end
    // Full horizontal ramp, 256 levels then 64 inverted levels
    for (int k = 0; k < 2; k++) begin
      wr(`VTPG_ADDR_CONFIG, {3'b000, k[0], 2'b00, k[0], 1'b0});
      wr(`VTPG_ADDR_SEL_CTRL, 8'h61);
      seek(8, 1 + k);
      for (int p = 0; p < 256; p++) begin
        if (p > 0) px(s, hh, vv);
        `CHK("hramp", colour(4'h6, 8'(p) & (k[0] ? 8'hfc : 8'hff), k[0], k[0]), vout.rgb)
      end
    end
    wr(`VTPG_ADDR_CONFIG, 8'h00);
    // Every ramp code, one line apart; vertical level is line * 256 levels / 4 lines = line * 64
    for (int c = 6; c < 14; c++) begin
      wr(`VTPG_ADDR_SEL_CTRL, {c[3:0], 4'h1});
      seek(c < 9 ? 136 : 8, (c - 6) % 4);
      `CHK("ramp", colour(c[3:0], c < 9 ? 8'h80 : 8'((c - 6) % 4 * 64), 1'b0, 1'b0), vout.rgb)
    end
    // Auto-scroll: starts at white whatever the select, then the one enabled code
    iw(`VTPG_IND_DWELL, 8'h01);
    iw(`VTPG_IND_PEN_LO, 8'h08);
    iw(`VTPG_IND_PEN_HI, 8'h00);
    seek(8, 1);
    wr(`VTPG_ADDR_CONFIG, 8'h01);
    wr(`VTPG_ADDR_SEL_CTRL, 8'h51);
    chk_px(24'hffffff);
    seek(8, 1);
    chk_px(24'hff0000);
    wr(`VTPG_ADDR_CONFIG, 8'h00);
    chk_px(24'h0000ff);
    // Internal timing from the divided clock, then from the pixel clock pin
    iw(`VTPG_IND_TOT_H_LO, 8'h10);
    iw(`VTPG_IND_TOT_V_LO, 8'h04);
    iw(`VTPG_IND_ACT_H_LO, 8'h08);
    iw(`VTPG_IND_ACT_H_HI, 8'h00);
    iw(`VTPG_IND_ACT_V_LO, 8'h02);
    iw(`VTPG_IND_HS_W, 8'h02);
    iw(`VTPG_IND_VS_W, 8'h01);
    iw(`VTPG_IND_HBP, 8'h02);
    iw(`VTPG_IND_VBP, 8'h01);
    for (int k = 0; k < 2; k++) begin
      wr(`VTPG_ADDR_CONFIG, {4'h0, k[0], 3'b100});
      repeat (1200) @(posedge clock);
      `CHK("de_run", k ? 64 : 16, de_run)
      `CHK("hs_run", k ? 16 : 4, hs_run)
    end
    conclude();
  end
endmodule
`default_nettype wire
